// ==== stack_and_shift_ops.sv ====
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module stack_and_shift_ops #(
    parameter logic [7:0] WDOG_KEY = 8'h5a
) (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      reset_n,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output var  logic [31:0]               prdata,
    output var  logic                      pready,
    output var  logic                      pslverr,
    // Memory bus
    output var  stack_shift_pkg::mem_req_t memOut,
    input  wire stack_shift_pkg::mem_rsp_t memIn,
    // Status
    output var  logic                      busy,
    output var  logic                      securityViolation
);
    import stack_shift_pkg::*;

    typedef enum {S_IDLE, S_RD1, S_RD2, S_WR, S_PAD} state_t;

    logic [1:0]  rstSync_r;
    logic        rstN;
    logic [15:0] regFile_r [REG_COUNT];
    state_t      state_r;
    op_t         op_r;
    logic        byte_r;
    logic        dstMem_r;
    logic [3:0]  idx_r;
    logic [15:0] ea_r;
    logic [15:0] index_r;
    logic [7:0]  cycCnt_r;
    logic [7:0]  lastCyc_r;
    logic        busy_r;
    logic        viol_r;
    mem_req_t    mem_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_r <= 2'b00;
        end else begin
            rstSync_r <= {rstSync_r[0], 1'b1};
        end
    end
    assign rstN = rstSync_r[1];

    ////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic [7:0] minCycles(input op_t op);
        case (op)
            OP_NOP:      minCycles = CYC_NOP;
            OP_JMP_NEXT: minCycles = CYC_JMP;
            OP_MOV_IDX:  minCycles = CYC_MOVIDX;
            default:     minCycles = CYC_OTHER;
        endcase
    endfunction : minCycles

    function automatic logic [1:0] laneEnable(input logic isByte, input logic addr0);
        laneEnable = isByte ? (addr0 ? 2'b10 : 2'b01) : 2'b11;
    endfunction : laneEnable

    function automatic shift_res_t shiftOp(input op_t op, input logic isByte,
                                           input logic [15:0] val, input logic [15:0] sr);
        shift_res_t  r;
        logic [16:0] sum;
        logic [8:0]  sumB;
        logic        cin;
        logic        cout;
        logic        ovf;
        r   = '{sr: sr, res: 16'h0000};
        cin = (op == OP_RLC) ? sr[SR_C] : 1'b0;
        sum = {1'b0, val} + {1'b0, val} + {16'h0000, cin};
        sumB = {1'b0, val[7:0]} + {1'b0, val[7:0]} + {8'h00, cin};
        ovf = (val >= WORD_V_LO) && (val < WORD_V_HI);
        cout = sum[16];
        if (isByte) begin
            ovf  = (val[7:0] >= BYTE_V_LO) && (val[7:0] < BYTE_V_HI);
            cout = sumB[8];
        end
        if (op == OP_SHR) begin
            r.res = isByte ? {8'h00, val[7], val[7:1]} : {val[15], val[15:1]};
            cout  = val[0];
            ovf   = 1'b0;
        end else begin
            r.res = isByte ? {8'h00, sumB[7:0]} : sum[15:0];
        end
        // high byte cleared in byte form
        // sign and zero of selected width
        r.sr[SR_N] = isByte ? r.res[7] : r.res[15];
        r.sr[SR_Z] = isByte ? (r.res[7:0] == 8'h00) : (r.res == 16'h0000);
        r.sr[SR_C] = cout;
        r.sr[SR_V] = ovf;
        shiftOp = r;
    endfunction : shiftOp

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    logic        apbDone;
    logic        isCtrl;
    logic        isStat;
    logic        isIndex;
    logic        isRegs;
    logic [3:0]  apbRegIdx;
    logic        startOk;
    logic        regWrOk;

    assign apbDone   = psel && penable && pready_r;
    assign isCtrl    = (paddr == OFS_CTRL);
    assign isStat    = (paddr == OFS_STAT);
    assign isIndex   = (paddr == OFS_INDEX);
    assign isRegs    = (paddr[7:6] == OFS_REGS[7:6]) && (paddr[1:0] == 2'b00);
    assign apbRegIdx = paddr[5:2];
    assign startOk   = apbDone && pwrite && isCtrl && !busy_r;
    assign regWrOk   = apbDone && pwrite && isRegs && !busy_r;

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= psel && penable && !pready_r;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            if (psel && penable && !pready_r) begin
                if (isStat) begin
                    prdata_r[STAT_BUSY]                  <= busy_r;
                    prdata_r[STAT_VIOL]                  <= viol_r;
                    prdata_r[STAT_CYC_LSB +: 8]          <= lastCyc_r;
                end else if (isIndex) begin
                    prdata_r[15:0] <= index_r;
                end else if (isRegs) begin
                    prdata_r[15:0] <= regFile_r[apbRegIdx];
                    pslverr_r      <= pwrite && busy_r;
                end else if (isCtrl) begin
                    prdata_r[CTRL_OP_LSB +: 4]  <= op_r;
                    prdata_r[CTRL_BYTE]         <= byte_r;
                    prdata_r[CTRL_MEM]          <= dstMem_r;
                    prdata_r[CTRL_IDX_LSB +: 4] <= idx_r;
                    pslverr_r                   <= pwrite && busy_r;
                end else begin
                    pslverr_r <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            index_r <= 16'h0000;
        end else if (apbDone && pwrite && isIndex) begin
            index_r <= pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operand and write-back steering
    logic        memDone;
    logic [15:0] sp;
    logic [15:0] spUp;
    logic [15:0] spDown;
    logic [7:0]  rdByte;
    logic [15:0] rdVal;
    logic [3:0]  startIdx;
    logic        startByte;
    op_t         startOp;
    shift_res_t  regShift;
    shift_res_t  memShift;
    logic        rfWeA;
    logic [3:0]  rfIdxA;
    logic [15:0] rfDataA;
    logic        rfWeSr;
    logic [15:0] rfDataSr;
    logic        rfWeSp;
    logic [15:0] rfDataSp;

    assign memDone   = mem_r.req && memIn.ready;
    assign sp        = regFile_r[IDX_SP];
    assign spUp      = sp + STACK_STEP;
    assign spDown    = sp - STACK_STEP;
    assign rdByte    = ea_r[0] ? memIn.rdata[15:8] : memIn.rdata[7:0];
    assign rdVal     = byte_r ? {8'h00, rdByte} : memIn.rdata;
    assign startIdx  = pwdata[CTRL_IDX_LSB +: 4];
    assign startByte = pwdata[CTRL_BYTE];
    assign startOp   = op_t'(pwdata[CTRL_OP_LSB +: 4]);
    assign regShift  = shiftOp(startOp, startByte, regFile_r[startIdx], regFile_r[IDX_SR]);
    assign memShift  = shiftOp(op_r, byte_r, rdVal, regFile_r[IDX_SR]);

    always_comb begin
        rfWeA    = 1'b0;
        rfIdxA   = idx_r;
        rfDataA  = rdVal;
        rfWeSr   = 1'b0;
        rfDataSr = regFile_r[IDX_SR];
        rfWeSp   = 1'b0;
        rfDataSp = sp;
        if (startOk && !pwdata[CTRL_MEM]) begin
            if (startOp == OP_SHL || startOp == OP_RLC || startOp == OP_SHR) begin
                // only N Z C V touched
                rfWeA    = 1'b1;
                rfIdxA   = startIdx;
                rfDataA  = regShift.res;
                rfWeSr   = 1'b1;
                rfDataSr = regShift.sr;
            end else if (startOp == OP_PUSH) begin
                rfWeSp   = 1'b1;
                rfDataSp = spDown;
            end
        end
        if (state_r == S_RD1 && memDone) begin
            case (op_r)
                OP_POP: begin
                    rfWeSp   = 1'b1;
                    rfDataSp = spUp;
                    // flags change only when popping into status
                    rfWeA    = !dstMem_r;
                    rfDataA  = byte_r ? {8'h00, memIn.rdata[7:0]} : memIn.rdata;
                end
                OP_PUSH: begin
                    rfWeSp   = 1'b1;
                    rfDataSp = spDown;
                end
                OP_RET: begin
                    rfWeA    = 1'b1;
                    rfIdxA   = IDX_PC;
                    rfDataA  = memIn.rdata;
                    rfWeSp   = 1'b1;
                    rfDataSp = spUp;
                end
                OP_INTERRUPT_RETURN: begin
                    rfWeSr   = 1'b1;
                    rfDataSr = memIn.rdata;
                    rfWeSp   = 1'b1;
                    rfDataSp = spUp;
                end
                OP_SHL, OP_RLC, OP_SHR: begin
                    rfWeSr   = 1'b1;
                    rfDataSr = memShift.sr;
                end
                default: begin
                end
            endcase
        end
        if (state_r == S_RD2 && memDone) begin
            rfWeA    = 1'b1;
            rfIdxA   = IDX_PC;
            rfDataA  = memIn.rdata;
            rfWeSp   = 1'b1;
            rfDataSp = spUp;
        end
        if (state_r == S_PAD && op_r == OP_JMP_NEXT && cycCnt_r >= minCycles(op_r) - 8'h01) begin
            rfWeA   = 1'b1;
            rfIdxA  = IDX_PC;
            rfDataA = regFile_r[IDX_PC] + PC_STEP;
        end
    end

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regFile_r[i] <= 16'h0000;
            end
        end else begin
            if (regWrOk) begin
                regFile_r[apbRegIdx] <= pwdata[15:0];
            end
            if (rfWeA) begin
                regFile_r[rfIdxA] <= rfDataA;
            end
            if (rfWeSr) begin
                regFile_r[IDX_SR] <= rfDataSr;
            end
            if (rfWeSp) begin
                regFile_r[IDX_SP] <= rfDataSp;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            state_r   <= S_IDLE;
            op_r      <= OP_NOP;
            byte_r    <= 1'b0;
            dstMem_r  <= 1'b0;
            idx_r     <= 4'h0;
            ea_r      <= 16'h0000;
            cycCnt_r  <= 8'h00;
            lastCyc_r <= 8'h00;
            busy_r    <= 1'b0;
            mem_r     <= '0;
        end else begin
            if (busy_r) begin
                cycCnt_r <= cycCnt_r + 8'h01;
            end
            if (memDone) begin
                mem_r.req <= 1'b0;
                mem_r.we  <= 1'b0;
            end
            case (state_r)
                S_IDLE: begin
                    if (startOk) begin
                        op_r     <= startOp;
                        byte_r   <= startByte;
                        dstMem_r <= pwdata[CTRL_MEM];
                        idx_r    <= startIdx;
                        ea_r     <= regFile_r[startIdx] + index_r;
                        cycCnt_r <= 8'h00;
                        busy_r   <= 1'b1;
                        state_r  <= S_PAD;
                        case (startOp)
                            OP_MOV_IDX: begin
                                mem_r   <= '{req: 1'b1, we: 1'b0, be: 2'b11,
                                             addr: regFile_r[startIdx] + index_r, wdata: 16'h0000};
                                state_r <= S_RD1;
                            end
                            OP_POP, OP_RET, OP_INTERRUPT_RETURN: begin
                                mem_r   <= '{req: 1'b1, we: 1'b0, be: 2'b11, addr: sp, wdata: 16'h0000};
                                state_r <= S_RD1;
                            end
                            OP_PUSH, OP_SHL, OP_RLC, OP_SHR: begin
                                if (pwdata[CTRL_MEM]) begin
                                    mem_r   <= '{req: 1'b1, we: 1'b0,
                                                 be: laneEnable(startByte, regFile_r[startIdx][0] ^ index_r[0]),
                                                 addr: regFile_r[startIdx] + index_r, wdata: 16'h0000};
                                    state_r <= S_RD1;
                                end else if (startOp == OP_PUSH) begin
                                    mem_r   <= '{req: 1'b1, we: 1'b1, be: laneEnable(startByte, 1'b0),
                                                 addr: spDown, wdata: regFile_r[startIdx]};
                                    state_r <= S_WR;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                S_RD1: begin
                    if (memDone) begin
                        state_r <= S_PAD;
                        case (op_r)
                            OP_MOV_IDX: begin
                                mem_r   <= '{req: 1'b1, we: 1'b1, be: 2'b11, addr: ea_r, wdata: memIn.rdata};
                                state_r <= S_WR;
                            end
                            OP_POP: begin
                                if (dstMem_r) begin
                                    mem_r   <= '{req: 1'b1, we: 1'b1, be: laneEnable(byte_r, ea_r[0]),
                                                 addr: ea_r, wdata: byte_r ? {2{memIn.rdata[7:0]}} : memIn.rdata};
                                    state_r <= S_WR;
                                end
                            end
                            OP_PUSH: begin
                                mem_r   <= '{req: 1'b1, we: 1'b1, be: laneEnable(byte_r, 1'b0),
                                             addr: spDown, wdata: rdVal};
                                state_r <= S_WR;
                            end
                            OP_INTERRUPT_RETURN: begin
                                mem_r   <= '{req: 1'b1, we: 1'b0, be: 2'b11, addr: spUp, wdata: 16'h0000};
                                state_r <= S_RD2;
                            end
                            OP_SHL, OP_RLC, OP_SHR: begin
                                mem_r   <= '{req: 1'b1, we: 1'b1, be: laneEnable(byte_r, ea_r[0]),
                                             addr: ea_r, wdata: byte_r ? {2{memShift.res[7:0]}} : memShift.res};
                                state_r <= S_WR;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                S_RD2, S_WR: begin
                    if (memDone) begin
                        state_r <= S_PAD;
                    end
                end
                S_PAD: begin
                    // stretched to the minimum cycle count
                    if (cycCnt_r >= minCycles(op_r) - 8'h01) begin
                        busy_r    <= 1'b0;
                        lastCyc_r <= cycCnt_r + 8'h01;
                        state_r   <= S_IDLE;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog key check
    logic wdogHit;
    logic violClr;

    assign wdogHit = memDone && mem_r.we && ({mem_r.addr[15:1], 1'b0} == WDOG_ADDR)
                     && ((mem_r.be != 2'b11) || (mem_r.wdata[15:8] != WDOG_KEY));
    assign violClr = apbDone && pwrite && isStat && pwdata[STAT_VIOL];

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            viol_r <= 1'b0;
        end else if (wdogHit) begin
            viol_r <= 1'b1;
        end else if (violClr) begin
            viol_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata            = prdata_r;
    assign pready            = pready_r;
    assign pslverr           = pslverr_r;
    assign memOut            = mem_r;
    assign busy              = busy_r;
    assign securityViolation = viol_r;
endmodule : stack_and_shift_ops
`default_nettype wire

// ==== stack_shift_pkg.sv ====
`default_nettype none
package stack_shift_pkg;
    // Register file layout
    localparam int          REG_COUNT   = 16;
    localparam logic [3:0]  IDX_PC      = 4'h0;
    localparam logic [3:0]  IDX_SP      = 4'h1;
    localparam logic [3:0]  IDX_SR      = 4'h2;
    // Status word bit positions
    localparam int          SR_C        = 0;
    localparam int          SR_Z        = 1;
    localparam int          SR_N        = 2;
    localparam int          SR_GIE      = 3;
    localparam int          SR_CORE_OFF = 4;
    localparam int          SR_OSC_OFF  = 5;
    localparam int          SR_V        = 8;
    // Stack step and overflow windows of a left shift
    localparam logic [15:0] STACK_STEP  = 16'h0002;
    localparam logic [15:0] WORD_V_LO   = 16'h4000;
    localparam logic [15:0] WORD_V_HI   = 16'hc000;
    localparam logic [7:0]  BYTE_V_LO   = 8'h40;
    localparam logic [7:0]  BYTE_V_HI   = 8'hc0;
    localparam logic [15:0] PC_STEP     = 16'h0002;
    // Watchdog control location
    localparam logic [15:0] WDOG_ADDR   = 16'h0120;
    // Minimum execution cycles
    localparam logic [7:0]  CYC_NOP     = 8'h01;
    localparam logic [7:0]  CYC_JMP     = 8'h02;
    localparam logic [7:0]  CYC_MOVIDX  = 8'h06;
    localparam logic [7:0]  CYC_OTHER   = 8'h01;
    // APB map
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_STAT    = 8'h04;
    localparam logic [7:0]  OFS_INDEX   = 8'h08;
    localparam logic [7:0]  OFS_REGS    = 8'h40;
    localparam int          CTRL_OP_LSB = 0;
    localparam int          CTRL_BYTE   = 4;
    localparam int          CTRL_MEM    = 5;
    localparam int          CTRL_IDX_LSB = 8;
    localparam int          STAT_BUSY   = 0;
    localparam int          STAT_VIOL   = 1;
    localparam int          STAT_CYC_LSB = 8;

    typedef enum logic [3:0] {
        OP_NOP, OP_JMP_NEXT, OP_MOV_IDX, OP_POP, OP_PUSH,
        OP_RET, OP_INTERRUPT_RETURN, OP_SHL, OP_RLC, OP_SHR
    } op_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [1:0]  be;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic        ready;
        logic [15:0] rdata;
    } mem_rsp_t;

    typedef struct packed {
        logic [15:0] sr;
        logic [15:0] res;
    } shift_res_t;
endpackage : stack_shift_pkg
`default_nettype wire

// ==== stack_shift_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module stack_shift_mem
    import stack_shift_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic [1:0]                waitN,
    input  wire stack_shift_pkg::mem_req_t memOut,
    output var  stack_shift_pkg::mem_rsp_t memIn
);
    logic [15:0] store [0:32767];
    logic [15:0] lastRd = 16'h0000;
    logic [1:0]  cnt    = 2'h0;
    assign memIn.ready = memOut.req && cnt == waitN;
    // Outside a completion the data lines flip every cycle
    assign memIn.rdata = memIn.ready ? store[memOut.addr[15:1]] : ~lastRd;
    always_ff @(posedge clk) begin
        cnt <= memIn.ready ? 2'h0 : cnt + {1'b0, memOut.req};
        lastRd <= memIn.rdata;
        if (memIn.ready && memOut.we && memOut.be[0]) store[memOut.addr[15:1]][7:0] <= memOut.wdata[7:0];
        if (memIn.ready && memOut.we && memOut.be[1]) store[memOut.addr[15:1]][15:8] <= memOut.wdata[15:8];
    end
endmodule : stack_shift_mem
`default_nettype wire

// ==== stack_and_shift_ops_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module stack_and_shift_ops_props
    import stack_shift_pkg::*;
#(parameter logic [7:0] WDOG_KEY = 8'h5a) (
    // Clock and reset
    input wire logic                      sys_clk,
    input wire logic                      reset_n,
    // APB slave
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [7:0]                paddr,
    input wire logic [31:0]               pwdata,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    // Memory bus
    input wire stack_shift_pkg::mem_req_t memOut,
    input wire stack_shift_pkg::mem_rsp_t memIn,
    // Status
    input wire logic                      busy,
    input wire logic                      securityViolation
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_access; psel && penable && !pready; endsequence
    a_ready_next: assert property (psel && penable && !$past(penable) |=> pready) else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    a_unmapped_err: assert property (s_access ##1 pready && $past(paddr) == 8'h0c |-> pslverr) else $error("no pslverr");
    a_req_hold: assert property (memOut.req && !memIn.ready |=> memOut.req && $stable(memOut.addr)) else $error("req lost");
    a_req_busy: assert property (memOut.req |-> busy) else $error("req while idle");
    a_viol_set: assert property (memOut.req && memIn.ready && memOut.we && memOut.addr[15:1] == 15'h0090
        && (memOut.be != 2'b11 || memOut.wdata[15:8] != WDOG_KEY) |=> securityViolation) else $error("no violation");
    a_viol_sticky: assert property (securityViolation && !(psel && penable && pready && pwrite) |=> securityViolation)
        else $error("violation lost");
endmodule : stack_and_shift_ops_props
bind stack_and_shift_ops stack_and_shift_ops_props #(.WDOG_KEY(WDOG_KEY)) props (.sys_clk, .reset_n, .psel,
    .penable, .pwrite, .pready, .pslverr, .busy, .securityViolation, .paddr, .pwdata, .prdata, .memOut, .memIn);
`default_nettype wire

// ==== stack_and_shift_ops_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module stack_and_shift_ops_tb;
    import stack_shift_pkg::*;
    logic sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, serr, busy, securityViolation;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0]  waitN = 2'h0;
    mem_req_t    memOut;
    mem_rsp_t    memIn;
    int          err_count = 0, checks_done = 0;
    always #2.5 sys_clk = ~sys_clk;
    stack_and_shift_ops dut (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .memOut, .memIn, .busy, .securityViolation);
    stack_shift_mem mem (.clk(sys_clk), .waitN, .memOut, .memIn);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic rdChk(input logic [3:0] i, input logic [15:0] e);
        apb(1'b0, {2'b01, i, 2'b00}, 32'h0);
        chk(rd, {16'h0, e});
    endtask : rdChk
    task automatic run(input logic [11:0] c);
        apb(1'b1, 8'h00, {20'h0, c});
        @(posedge sys_clk);
        repeat (64) if (busy) @(posedge sys_clk);
    endtask : run
    // Preset status and R7, run one shift, read both back
    task automatic sh(input logic [3:0] op, input logic b, input logic [15:0] v, s, r, es);
        apb(1'b1, 8'h48, {16'h0, s});
        apb(1'b1, 8'h5c, {16'h0, v});
        run({4'h7, 3'b000, b, op});
        rdChk(4'h7, r);
        rdChk(4'h2, es);
    endtask : sh
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        #100000;
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        mem.store[16'h0100] = 16'h8000;
        mem.store[16'h0101] = 16'h0021;
        mem.store[16'h0102] = 16'h4444;
        mem.store[16'h0090] = 16'h0000;
        mem.store[16'h0103] = 16'hab12;
        mem.store[16'h0110] = 16'h5566;
        apb(1'b1, 8'h44, 32'h0200);
        apb(1'b1, 8'h48, 32'h013f);
        apb(1'b1, 8'h50, 32'h1234);
        waitN <= 2'h2;
        run(12'h404);
        rdChk(4'h1, 16'h01fe);
        chk(mem.store[16'h00ff], 16'h1234);
        run(12'h414);
        rdChk(4'h1, 16'h01fc);
        chk(mem.store[16'h00fe][7:0], 8'h34);
        run(12'h513);
        rdChk(4'h5, 16'h0034);
        rdChk(4'h1, 16'h01fe);
        run(12'h603);
        rdChk(4'h6, 16'h1234);
        rdChk(4'h2, 16'h013f);
        run(12'h005);
        rdChk(4'h0, 16'h8000);
        run(12'h006);
        rdChk(4'h2, 16'h0021);
        rdChk(4'h0, 16'h4444);
        rdChk(4'h1, 16'h0206);
        // Byte pop into the odd byte of a memory word
        apb(1'b1, 8'h64, 32'h0221);
        run(12'h933);
        chk(mem.store[16'h0110], 16'h1266);
        rdChk(4'h1, 16'h0208);
        waitN <= 2'h0;
        sh(4'h7, 1'b0, 16'h4000, 16'h0038, 16'h8000, 16'h013c);
        sh(4'h7, 1'b0, 16'hc000, 16'h0038, 16'h8000, 16'h003d);
        sh(4'h8, 1'b0, 16'h8000, 16'h0039, 16'h0001, 16'h0139);
        sh(4'h8, 1'b1, 16'hff40, 16'h0038, 16'h0080, 16'h013c);
        sh(4'h7, 1'b1, 16'h1280, 16'h0038, 16'h0000, 16'h013b);
        sh(4'h9, 1'b0, 16'h8001, 16'h0138, 16'hc000, 16'h003d);
        sh(4'h9, 1'b1, 16'hff81, 16'h0038, 16'h00c0, 16'h003d);
        run(12'h001);
        rdChk(4'h0, 16'h4446);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[15:8], 8'h02);
        run(12'h000);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[15:8], 8'h01);
        apb(1'b1, 8'h60, 32'h0100);
        apb(1'b1, 8'h08, 32'h0020);
        run(12'h822);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[1], 1'b1);
        chk(securityViolation, 1'b1);
        chk(rd[15:8] >= 8'h06, 1'b1);
        apb(1'b1, 8'h04, 32'h2);
        apb(1'b0, 8'h0c, 32'h0);
        chk({serr, rd[1:0]}, 3'h4);
        chk(securityViolation, 1'b0);
        end_of_test();
    end
endmodule : stack_and_shift_ops_tb
`default_nettype wire
